/* logic/pirc_map.vh */
// Constants for the power-down isolation and refresh controller
`ifndef PIRC_MAP_VH
`define PIRC_MAP_VH
// ****************************************************************
// Power mode control bit positions
// ****************************************************************
`define PIRC_PMC_SYS_SEL 7
`define PIRC_PMC_CLK_INT 6
`define PIRC_PMC_ISOLATE 5
// ****************************************************************
// Refresh interval register fields
// ****************************************************************
`define PIRC_RI_GEN_EN 7
`define PIRC_RI_MSB 6
`define PIRC_RI_OFFSET 8'h05
`define PIRC_RI_RESET 8'h00
`define PIRC_PMC_RESET 8'h00
// ****************************************************************
// Refresh per line codes and clock division
// ****************************************************************
`define PIRC_RPL_TWO 2'h3
`define PIRC_RPL_ONE 2'h1
`define PIRC_CHAR_DIV 3'h7
// ****************************************************************
// Mode codes
// ****************************************************************
`define PIRC_MODE_NORMAL 3'h0
`define PIRC_MODE_SYSTEM 3'h1
`define PIRC_MODE_IDLE 3'h2
`define PIRC_MODE_GEN_EXT 3'h3
`define PIRC_MODE_GEN_INT 3'h4
`endif

/* logic/pirc_char_div.v */
// Divide-by-eight character clock enable generator
`timescale 1ns/1ns
`default_nettype none
`include "pirc_map.vh"
module pirc_char_div (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire run,
  // Tick out, one cycle every eight
  output wire tick
);
  reg [2:0] phase;

  // Free-running phase, parked while not running
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 3'h0;
    end else if (!run) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  assign tick = run && (phase == `PIRC_CHAR_DIV);
endmodule
`default_nettype wire

/* logic/pirc_ctl.v */
// Power-down isolation, sleep refresh timing and pin forcing
// Functional notes
// - Power-down low with the isolate bit set disconnects from the host bus in any mode.
// - While isolated all host outputs are released and host accesses are not answered.
// - Select code 11 gives two refreshes per line and code 01 gives one.
// - With general enable set, clock bit clear means external control, set means divide by 8.
// - System power-down releases data bus, ready, interrupt, 16-bit select and DRAM data.
// - In all four modes panel data, strobes, shift clocks and colour outputs are held low.
// - System mode: ROM, directions, DRAM OE, writes, address, palette high; pixel clock low.
// - Row and column strobes and panel select stay normal; the system-mode pins above are normal outside system mode.
// - General modes time refresh from the interval register, not display timing.
// - Both select bits clear gives display idle mode on power-down.
// - Display idle divides internal clocks by eight.
`timescale 1ns/1ns
`default_nettype none
`include "pirc_map.vh"
module pirc_ctl (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Power manager and configuration
  input wire sleep_request_n,
  input wire [7:0] power_mode_control,
  input wire [7:0] sleep_refresh_interval,
  input wire [1:0] refresh_per_line_select,
  // Normal host-side values from the core
  input wire host_access,
  input wire [15:0] sd_out_core,
  input wire sd_oe_n_core,
  input wire iochrdy_core,
  input wire irq_core,
  input wire memcs16_core,
  input wire bios_rom_enable_core,
  input wire upper_byte_buffer_dir_core,
  input wire lower_byte_buffer_dir_core,
  // Normal memory-side values from the core
  input wire [1:0] dram_output_enable_core,
  input wire [3:0] write_strobe_core,
  input wire [8:0] dram_row_col_lines_core,
  input wire [15:0] dram_word_bus_core,
  input wire dram_word_bus_oe_n_core,
  input wire row_strobe_upper_core,
  input wire row_strobe_lower_core,
  input wire column_strobe_upper_core,
  input wire column_strobe_lower_core,
  input wire panel_select_core,
  // Normal panel and palette values from the core
  input wire [3:0] upper_panel_nibble_core,
  input wire [3:0] lower_panel_nibble_core,
  input wire [4:0] panel_strobes_core,
  input wire [1:0] palette_strobes_core,
  input wire pixel_clock_core,
  input wire [2:0] rgb_core,
  // Host interface pins
  output reg [15:0] sd_out,
  output reg sd_oe_n,
  output reg iochrdy,
  output reg iochrdy_oe_n,
  output reg irq,
  output reg irq_oe_n,
  output reg memcs16,
  output reg memcs16_oe_n,
  output reg bios_rom_enable,
  output reg bios_rom_enable_oe_n,
  output reg upper_byte_buffer_dir,
  output reg lower_byte_buffer_dir,
  output reg buffer_dir_oe_n,
  output wire host_accept,
  // Memory pins
  output reg dram_output_enable_upper,
  output reg dram_output_enable_lower,
  output reg [3:0] write_strobe,
  output reg [8:0] dram_row_col_lines,
  output reg [15:0] dram_word_bus,
  output reg dram_word_bus_oe_n,
  output reg row_strobe_upper,
  output reg row_strobe_lower,
  output reg column_strobe_upper,
  output reg column_strobe_lower,
  output reg panel_select_output,
  // Panel and palette pins
  output reg [3:0] upper_panel_nibble,
  output reg [3:0] lower_panel_nibble,
  output reg ac_drive_modulation,
  output reg vertical_start_strobe,
  output reg row_latch_strobe,
  output reg panel_shift_clock,
  output reg gray_weight_clock,
  output reg palette_read_strobe,
  output reg palette_write_strobe,
  output reg pixel_clock,
  output reg [2:0] rgb,
  // Status
  output reg [2:0] sleep_mode,
  output reg isolated,
  output wire clock_div8,
  output wire char_tick,
  output reg refresh_request,
  output reg refresh_pair
);
  // ****************************************************************
  // Mode decode
  // ****************************************************************
  reg [7:0] held_ri;
  reg [1:0] held_rpl;
  reg sleep_d;
  reg [7:0] char_count;
  reg refresh_second;
  wire sleeping;
  wire sys_mode;
  wire gen_mode;
  wire [7:0] interval_end;

  // Decodes mode from control bytes
  function [2:0] pirc_decode;
    input [7:0] pmc;
    input [7:0] ri;
    begin
      if (pmc[`PIRC_PMC_SYS_SEL]) begin
        pirc_decode = `PIRC_MODE_SYSTEM;
      end else if (ri[`PIRC_RI_GEN_EN]) begin
        pirc_decode = pmc[`PIRC_PMC_CLK_INT] ? `PIRC_MODE_GEN_INT : `PIRC_MODE_GEN_EXT;
      end else begin
        pirc_decode = `PIRC_MODE_IDLE;
      end
    end
  endfunction

  assign sleeping = (sleep_mode != `PIRC_MODE_NORMAL);
  assign sys_mode = (sleep_mode == `PIRC_MODE_SYSTEM);
  assign gen_mode = (sleep_mode == `PIRC_MODE_GEN_EXT) || (sleep_mode == `PIRC_MODE_GEN_INT);
  // idle and internal mode divide by eight
  assign clock_div8 = (sleep_mode == `PIRC_MODE_IDLE) || (sleep_mode == `PIRC_MODE_GEN_INT);
  // terminal count is interval plus five
  assign interval_end = {1'b0, held_ri[`PIRC_RI_MSB:0]} + `PIRC_RI_OFFSET;
  // no host access taken while isolated
  assign host_accept = host_access && !isolated;

  // sample mode bits at falling edge, hold till rise
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_d <= 1'b1;
      held_ri <= `PIRC_RI_RESET;
      held_rpl <= 2'h0;
      sleep_mode <= `PIRC_MODE_NORMAL;
      isolated <= 1'b0;
    end else begin
      sleep_d <= sleep_request_n;
      if (sleep_d && !sleep_request_n) begin
        held_ri <= sleep_refresh_interval;
        held_rpl <= refresh_per_line_select;
        sleep_mode <= pirc_decode(power_mode_control, sleep_refresh_interval);
        isolated <= power_mode_control[`PIRC_PMC_ISOLATE];
      end else if (sleep_request_n) begin
        // high input ends sleep and isolation
        sleep_mode <= `PIRC_MODE_NORMAL;
        isolated <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sleep refresh timer
  // ****************************************************************
  pirc_char_div u_char_div (
    .clk(clk),
    .rst_n(rst_n),
    .run(gen_mode),
    .tick(char_tick)
  );

  // general modes time refresh from interval register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      char_count <= 8'h00;
      refresh_request <= 1'b0;
      refresh_pair <= 1'b0;
      refresh_second <= 1'b0;
    end else begin
      refresh_request <= 1'b0;
      if (!gen_mode) begin
        char_count <= 8'h00;
        refresh_second <= 1'b0;
      end else if (refresh_second) begin
        // Second refresh one cycle after the first
        refresh_request <= 1'b1;
        refresh_second <= 1'b0;
      end else if (char_tick) begin
        if (char_count >= interval_end) begin
          char_count <= 8'h00;
          refresh_request <= 1'b1;
          // code 11 two refreshes, 01 one
          refresh_pair <= (held_rpl == `PIRC_RPL_TWO);
          refresh_second <= (held_rpl == `PIRC_RPL_TWO);
        end else begin
          char_count <= char_count + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Pin forcing, registered
  // ****************************************************************
  // Forced values registered so outputs stay glitch-free across mode changes
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sd_out <= 16'h0000;
      sd_oe_n <= 1'b1;
      iochrdy <= 1'b1;
      iochrdy_oe_n <= 1'b1;
      irq <= 1'b0;
      irq_oe_n <= 1'b1;
      memcs16 <= 1'b1;
      memcs16_oe_n <= 1'b1;
      bios_rom_enable <= 1'b1;
      bios_rom_enable_oe_n <= 1'b1;
      upper_byte_buffer_dir <= 1'b1;
      lower_byte_buffer_dir <= 1'b1;
      buffer_dir_oe_n <= 1'b1;
      dram_output_enable_upper <= 1'b1;
      dram_output_enable_lower <= 1'b1;
      write_strobe <= 4'hf;
      dram_row_col_lines <= 9'h1ff;
      dram_word_bus <= 16'h0000;
      dram_word_bus_oe_n <= 1'b1;
      row_strobe_upper <= 1'b1;
      row_strobe_lower <= 1'b1;
      column_strobe_upper <= 1'b1;
      column_strobe_lower <= 1'b1;
      panel_select_output <= 1'b1;
      upper_panel_nibble <= 4'h0;
      lower_panel_nibble <= 4'h0;
      ac_drive_modulation <= 1'b0;
      vertical_start_strobe <= 1'b0;
      row_latch_strobe <= 1'b0;
      panel_shift_clock <= 1'b0;
      gray_weight_clock <= 1'b0;
      palette_read_strobe <= 1'b1;
      palette_write_strobe <= 1'b1;
      pixel_clock <= 1'b0;
      rgb <= 3'h0;
    end else begin
      sd_out <= sd_out_core;
      sd_oe_n <= sd_oe_n_core || sys_mode || isolated;
      iochrdy <= iochrdy_core;
      iochrdy_oe_n <= sys_mode || isolated;
      irq <= irq_core;
      irq_oe_n <= sys_mode || isolated;
      memcs16 <= memcs16_core;
      memcs16_oe_n <= sys_mode || isolated;
      dram_word_bus <= dram_word_bus_core;
      dram_word_bus_oe_n <= dram_word_bus_oe_n_core || sys_mode;
      // remaining host outputs released when isolated
      bios_rom_enable_oe_n <= isolated;
      buffer_dir_oe_n <= isolated;
      // system mode drives high, pixel clock low
      bios_rom_enable <= sys_mode || bios_rom_enable_core;
      upper_byte_buffer_dir <= sys_mode || upper_byte_buffer_dir_core;
      lower_byte_buffer_dir <= sys_mode || lower_byte_buffer_dir_core;
      dram_output_enable_upper <= sys_mode || dram_output_enable_core[1];
      dram_output_enable_lower <= sys_mode || dram_output_enable_core[0];
      write_strobe <= sys_mode ? 4'hf : write_strobe_core;
      dram_row_col_lines <= sys_mode ? 9'h1ff : dram_row_col_lines_core;
      palette_read_strobe <= sys_mode || palette_strobes_core[1];
      palette_write_strobe <= sys_mode || palette_strobes_core[0];
      pixel_clock <= !sys_mode && pixel_clock_core;
      // refresh strobes and panel select always pass
      row_strobe_upper <= row_strobe_upper_core;
      row_strobe_lower <= row_strobe_lower_core;
      column_strobe_upper <= column_strobe_upper_core;
      column_strobe_lower <= column_strobe_lower_core;
      panel_select_output <= panel_select_core;
      // panel and colour outputs low in all sleep modes
      upper_panel_nibble <= sleeping ? 4'h0 : upper_panel_nibble_core;
      lower_panel_nibble <= sleeping ? 4'h0 : lower_panel_nibble_core;
      ac_drive_modulation <= !sleeping && panel_strobes_core[4];
      vertical_start_strobe <= !sleeping && panel_strobes_core[3];
      row_latch_strobe <= !sleeping && panel_strobes_core[2];
      panel_shift_clock <= !sleeping && panel_strobes_core[1];
      gray_weight_clock <= !sleeping && panel_strobes_core[0];
      rgb <= sleeping ? 3'h0 : rgb_core;
    end
  end
endmodule
`default_nettype wire

/* dv/pirc_ctl_monitor.sv */
// Concurrent checks on the power-down controller ports
`timescale 1ns/1ns
`default_nettype none
module pirc_ctl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and core side
  input wire logic sleep_request_n,
  input wire logic [7:0] power_mode_control,
  input wire logic [7:0] sleep_refresh_interval,
  input wire logic row_strobe_upper_core,
  // Pins and status
  input wire logic [2:0] sleep_mode,
  input wire logic isolated,
  input wire logic host_accept,
  input wire logic sd_oe_n,
  input wire logic iochrdy_oe_n,
  input wire logic [3:0] write_strobe,
  input wire logic [8:0] dram_row_col_lines,
  input wire logic pixel_clock,
  input wire logic dram_word_bus_oe_n,
  input wire logic [3:0] upper_panel_nibble,
  input wire logic [2:0] rgb,
  input wire logic row_strobe_upper,
  input wire logic clock_div8,
  input wire logic refresh_request,
  input wire logic refresh_pair
);
  // ****************************************
  // Checks, all in the one clock domain
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  iso_entry_a: assert property ($fell(sleep_request_n) && power_mode_control[5] |=>
    isolated)
    else $error("isolation not taken");
  iso_gate_a: assert property (isolated |-> !host_accept)
    else $error("host access answered while isolated");
  iso_float_a: assert property (isolated |=> sd_oe_n && iochrdy_oe_n)
    else $error("host pins driven while isolated");
  iso_exit_a: assert property (sleep_request_n && isolated |-> ##[1:2] !isolated)
    else $error("isolation kept after wake");
  sys_pins_a: assert property (sleep_mode == 3'h1 |=> write_strobe == 4'hf &&
    dram_row_col_lines == 9'h1ff && !pixel_clock && dram_word_bus_oe_n)
    else $error("system mode pins wrong");
  panel_low_a: assert property (sleep_mode != 3'h0 |=>
    upper_panel_nibble == 4'h0 && rgb == 3'h0)
    else $error("panel pins not low");
  strobe_pass_a: assert property ($past(rst_n) |->
    row_strobe_upper == $past(row_strobe_upper_core))
    else $error("row strobe not passed through");
  // Divide choice judged from the bits seen at the falling request
  div_mode_a: assert property ($fell(sleep_request_n) && !power_mode_control[7] |=>
    clock_div8 == ($past(power_mode_control[6]) || !$past(sleep_refresh_interval[7])))
    else $error("clock divide wrong for mode");
  // Only a request held low for two samples counts as steady sleep
  mode_hold_a: assert property ($past(sleep_mode) != 3'h0 && !$past(sleep_request_n) &&
    !sleep_request_n |-> $stable(sleep_mode))
    else $error("mode changed during sleep");
  pair_twice_a: assert property ($rose(refresh_request) && refresh_pair |=>
    refresh_request)
    else $error("second refresh missing");
  single_once_a: assert property ($rose(refresh_request) && !refresh_pair |=>
    !refresh_request)
    else $error("extra refresh pulse");
  // A pulse launched on the wake edge still belongs to the general mode
  ref_mode_a: assert property (refresh_request |->
    $past(sleep_mode) == 3'h3 || $past(sleep_mode) == 3'h4)
    else $error("refresh outside general modes");
  // Main scenarios reached
  cover property (sleep_mode == 3'h1);
  cover property (isolated);
  cover property ($rose(refresh_request) && refresh_pair);
endmodule
bind pirc_ctl pirc_ctl_monitor mon (.*);
`default_nettype wire

/* dv/pirc_pm_model.sv */
// Power manager model driving the sleep request and interval setup
`timescale 1ns/1ns
`default_nettype none
module pirc_pm_model (
  // Clock
  input wire logic clk,
  // Command from the bench
  input wire logic sleep_cmd,
  // Request to the controller
  output var logic sleep_request_n
);
  // wake by high
  // Changes only after a falling edge so the controller samples it cleanly
  initial sleep_request_n = 1'b1;
  always @(negedge clk) begin
    sleep_request_n <= ~sleep_cmd;
  end
  // interval value
  // Clock period is the slowed or video clock by mode; rounded to nearest
  function automatic logic [6:0] interval_for(input int period_ns, input int rpl,
    input int clk_ns);
    int q2;
    q2 = (2 * period_ns * rpl) / (8 * clk_ns);
    return 7'((q2 + 1) / 2 - 5);
  endfunction
endmodule
`default_nettype wire

/* dv/pirc_ctl_tb_top.sv */
// Self-checking bench for the power-down controller
`timescale 1ns/1ns
`default_nettype none
module pirc_ctl_tb_top;
  // Stimulus
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleep_cmd = 1'b0;
  logic host_access = 1'b1;
  logic [7:0] power_mode_control = 8'h00;
  logic [7:0] sleep_refresh_interval = 8'h00;
  logic [1:0] refresh_per_line_select = 2'h1;
  logic [15:0] sd_out_core, dram_word_bus_core;
  logic sd_oe_n_core, iochrdy_core, irq_core, memcs16_core, bios_rom_enable_core;
  logic upper_byte_buffer_dir_core, lower_byte_buffer_dir_core, dram_word_bus_oe_n_core;
  logic row_strobe_upper_core, row_strobe_lower_core, column_strobe_upper_core;
  logic column_strobe_lower_core, panel_select_core, pixel_clock_core;
  logic [1:0] dram_output_enable_core, palette_strobes_core;
  logic [3:0] write_strobe_core, upper_panel_nibble_core, lower_panel_nibble_core;
  logic [8:0] dram_row_col_lines_core;
  logic [4:0] panel_strobes_core;
  logic [2:0] rgb_core;
  // Design outputs
  wire sleep_request_n;
  wire [15:0] sd_out, dram_word_bus;
  wire sd_oe_n, iochrdy, iochrdy_oe_n, irq, irq_oe_n, memcs16, memcs16_oe_n, host_accept;
  wire bios_rom_enable, bios_rom_enable_oe_n, upper_byte_buffer_dir, lower_byte_buffer_dir;
  wire buffer_dir_oe_n, dram_output_enable_upper, dram_output_enable_lower, dram_word_bus_oe_n;
  wire row_strobe_upper, row_strobe_lower, column_strobe_upper, column_strobe_lower;
  wire panel_select_output, ac_drive_modulation, vertical_start_strobe, row_latch_strobe;
  wire panel_shift_clock, gray_weight_clock, palette_read_strobe, palette_write_strobe;
  wire pixel_clock, isolated, clock_div8, char_tick, refresh_request, refresh_pair;
  wire [3:0] write_strobe, upper_panel_nibble, lower_panel_nibble;
  wire [8:0] dram_row_col_lines;
  wire [2:0] rgb, sleep_mode;
  int fails = 0;
  int total_checks = 0;
  pirc_ctl uut (.*);
  pirc_pm_model pm (.clk(clk), .sleep_cmd(sleep_cmd), .sleep_request_n(sleep_request_n));
  // 50 MHz clock; a toggling strobe shows pass-through
  always #10 clk = ~clk;
  always @(negedge clk) row_strobe_upper_core <= ~row_strobe_upper_core;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Config is set before the request falls, then held
  task automatic sleep(input logic [7:0] pmc, input logic [7:0] ri, input logic [1:0] rpl);
    power_mode_control = pmc;
    sleep_refresh_interval = ri;
    refresh_per_line_select = rpl;
    sleep_cmd <= 1'b1;
    repeat (4) @(negedge clk);
  endtask
  task automatic wake;
    sleep_cmd <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic panel_low;
    chk({upper_panel_nibble, lower_panel_nibble, ac_drive_modulation, vertical_start_strobe,
      row_latch_strobe, panel_shift_clock, gray_weight_clock, rgb}, 32'h0);
  endtask
  // Cycles from one refresh to the next; a pair must show a second pulse
  task automatic measure(input logic pair, input int exp_cycles);
    int n;
    n = 0;
    while (refresh_request !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        fails++;
        tally_and_finish();
      end
    end
    @(negedge clk);
    chk(refresh_request, pair);
    @(negedge clk);
    n = 2;
    while (refresh_request !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n, exp_cycles);
  endtask
  task automatic t_system;
    sleep(8'h80, 8'h00, 2'h1);
    chk(sleep_mode, 3'h1);
    chk({sd_oe_n, iochrdy_oe_n, irq_oe_n, memcs16_oe_n, dram_word_bus_oe_n}, 5'h1f);
    chk({bios_rom_enable, upper_byte_buffer_dir, lower_byte_buffer_dir, dram_output_enable_upper,
      dram_output_enable_lower, write_strobe, dram_row_col_lines, palette_read_strobe,
      palette_write_strobe, pixel_clock}, {5'h1f, 4'hf, 9'h1ff, 2'h3, 1'b0});
    panel_low();
    chk({row_strobe_upper, panel_select_output},
      {row_strobe_upper_core, panel_select_core});
    wake();
    chk({sd_oe_n, write_strobe}, 5'h00);
  endtask
  task automatic t_idle;
    sleep(8'h00, 8'h00, 2'h1);
    chk({sleep_mode, clock_div8}, {3'h2, 1'b1});
    panel_low();
    chk({bios_rom_enable, write_strobe, sd_oe_n, pixel_clock, host_accept}, 8'h03);
    chk({sd_out, dram_word_bus}, {16'h5a3c, 16'hc3a5});
    chk({iochrdy, irq, memcs16, row_strobe_lower, column_strobe_upper,
      column_strobe_lower}, 6'h00);
    power_mode_control = 8'h80;
    repeat (2) @(negedge clk);
    chk(sleep_mode, 3'h2);
    wake();
  endtask
  task automatic t_general;
    int ticks;
    sleep(8'h00, {1'b1, pm.interval_for(15000, 2, 200)}, 2'h3);
    chk({sleep_mode, clock_div8}, {3'h3, 1'b0});
    panel_low();
    // Any sixteen cycles in a general mode hold exactly two character ticks
    ticks = 0;
    repeat (16) begin
      @(negedge clk);
      ticks += char_tick;
    end
    chk(ticks, 2);
    measure(1'b1, (14 + 6) * 8);
    wake();
    sleep(8'h40, {1'b1, pm.interval_for(15000, 1, 286)}, 2'h1);
    chk({sleep_mode, clock_div8}, {3'h4, 1'b1});
    panel_low();
    measure(1'b0, (2 + 6) * 8);
    wake();
  endtask
  task automatic t_isolate;
    sleep(8'h20, 8'h00, 2'h1);
    chk({isolated, host_accept, sleep_mode}, {1'b1, 1'b0, 3'h2});
    chk({sd_oe_n, iochrdy_oe_n, irq_oe_n, memcs16_oe_n, bios_rom_enable_oe_n, buffer_dir_oe_n},
      6'h3f);
    wake();
    chk({isolated, host_accept, sd_oe_n}, 3'h2);
  endtask
  initial begin
    {sd_out_core, dram_word_bus_core, sd_oe_n_core, iochrdy_core, irq_core, memcs16_core} = '0;
    // Distinct data words so a pass-through slip shows up
    sd_out_core = 16'h5a3c;
    dram_word_bus_core = 16'hc3a5;
    {bios_rom_enable_core, upper_byte_buffer_dir_core, lower_byte_buffer_dir_core} = '0;
    {dram_word_bus_oe_n_core, row_strobe_upper_core, row_strobe_lower_core} = '0;
    {column_strobe_upper_core, column_strobe_lower_core, panel_select_core} = '0;
    {dram_output_enable_core, palette_strobes_core, write_strobe_core} = '0;
    dram_row_col_lines_core = 9'h000;
    {upper_panel_nibble_core, lower_panel_nibble_core, panel_strobes_core} = '1;
    {rgb_core, pixel_clock_core} = '1;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_system();
    t_idle();
    t_general();
    t_isolate();
    tally_and_finish();
  end
endmodule
`default_nettype wire
